//--- src/prad_pkg.sv
// Package: constants for the paged register address decoder
package prad_pkg;
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 8;
	localparam int SPI_ADDR_W  = 7;
	localparam logic PAGE_RST  = 1'h0;
	// Register holding the page selector and its bit position
	localparam logic [7:0] PAGE_REG_ADDR = 8'h73;
	localparam int         PAGE_BIT      = 4;
	localparam logic [7:0] DATA_RST      = 8'h00;
	localparam logic [7:0] ADDR_RST      = 8'h00;
	localparam logic       ACK_RST       = 1'h0;
	localparam int SYNC_STAGES = 3;
endpackage : prad_pkg

//--- src/prad_if.sv
// Interface: decoded access carried from the decoder to the storage slice
`timescale 1ns/1ps
interface prad_if;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport dec (output wr, output addr, output wdata, input rdata);
	modport mem (input wr, input addr, input wdata, output rdata);
endinterface : prad_if

//--- src/prad_store.sv
// Storage slice: 8-bit register array behind the decoded address
`timescale 1ns/1ps
module prad_store #(
	parameter int DEPTH = 256
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic [DEPTH-1:0] writable,
	prad_if.mem       acc
);
	logic [7:0] mem_ff [DEPTH];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++)
				mem_ff[i] <= prad_pkg::DATA_RST;
		end else if (ce && acc.wr && writable[acc.addr]) begin
			mem_ff[acc.addr] <= acc.wdata;
		end
	end

	assign acc.rdata = mem_ff[acc.addr];
endmodule : prad_store

//--- src/prad_top.sv
// Top: page-aware register address decoder for the I2C and SPI paths
//
// Summary of operation
// - Every register holds eight bits; each access moves one byte.
// - I2C uses full eight-bit address; page selector ignored.
// - SPI supplies seven address bits; page selector resolves the top bit.
// - After reset page 0 active: SPI maps to 0x80 through 0xFF.
// - Page selector at one maps SPI to 0x00 through 0x7F.
`timescale 1ns/1ps
module prad_top #(
	parameter logic [255:0] WRITABLE = {256{1'b1}}
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       ce,
	input  wire logic       is_spi,
	input  wire logic       req,
	input  wire logic       wr,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	output logic            ack_ff,
	output logic [7:0]      rdata_ff,
	output logic [7:0]      int_addr_ff,
	output logic            page_ff
);
	// ------------------------------------------------------------
	// Local types
	// ------------------------------------------------------------
	typedef enum {
		PRAD_RESP_IDLE,
		PRAD_RESP_ACK
	} prad_resp_t;

	localparam int MAP_DEPTH = 1 << prad_pkg::ADDR_W;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	prad_if acc ();

	prad_resp_t                        resp_ff;
	prad_resp_t                        nxt_resp;
	logic                              take;
	logic                              wr_take;
	logic                              page_hit;
	logic [prad_pkg::SPI_ADDR_W-1:0]   spi_low;
	logic [prad_pkg::ADDR_W-1:0]       nxt_addr;
	logic                              nxt_page;
	logic                              nxt_ack;
	logic [prad_pkg::ADDR_W-1:0]       nxt_int_addr;
	logic [prad_pkg::DATA_W-1:0]       nxt_rdata;
	logic [MAP_DEPTH-1:0]              wr_mask;

	// ------------------------------------------------------------
	// Access qualification
	// ------------------------------------------------------------
	// A request only counts on an enabled edge
	always_comb begin
		take    = ce && req;
		wr_take = ce && req && wr;
	end

	// ------------------------------------------------------------
	// Address resolution
	// ------------------------------------------------------------
	always_comb begin
		spi_low  = addr[prad_pkg::SPI_ADDR_W-1:0];
		nxt_addr = addr;
		if (is_spi) begin
			nxt_addr = {~page_ff, spi_low};
		end
	end

	// ------------------------------------------------------------
	// Page selector
	// ------------------------------------------------------------
	// Decoded on the resolved address, so I2C always reaches it and SPI only on page 1
	always_comb begin
		page_hit = (nxt_addr == prad_pkg::PAGE_REG_ADDR);
	end

	always_comb begin
		nxt_page = page_ff;
		if (wr_take && page_hit) begin
			nxt_page = wdata[prad_pkg::PAGE_BIT];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			page_ff <= prad_pkg::PAGE_RST;
		end else if (ce) begin
			page_ff <= nxt_page;
		end
	end

	// ------------------------------------------------------------
	// Response sequencing
	// ------------------------------------------------------------
	always_comb begin
		nxt_resp = resp_ff;
		case (resp_ff)
			PRAD_RESP_IDLE: begin
				if (take) begin
					nxt_resp = PRAD_RESP_ACK;
				end
			end
			PRAD_RESP_ACK: begin
				// Back-to-back requests keep the answer raised
				if (!take) begin
					nxt_resp = PRAD_RESP_IDLE;
				end
			end
			default: begin
				nxt_resp = PRAD_RESP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resp_ff <= PRAD_RESP_IDLE;
		end else if (ce) begin
			resp_ff <= nxt_resp;
		end
	end

	always_comb begin
		nxt_ack = (nxt_resp == PRAD_RESP_ACK);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_ff <= prad_pkg::ACK_RST;
		end else if (ce) begin
			ack_ff <= nxt_ack;
		end
	end

	// ------------------------------------------------------------
	// Captured address and read data
	// ------------------------------------------------------------
	always_comb begin
		nxt_int_addr = int_addr_ff;
		nxt_rdata    = rdata_ff;
		if (take) begin
			nxt_int_addr = nxt_addr;
			// Old contents: a write answers with what it replaced
			nxt_rdata    = acc.rdata;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_addr_ff <= prad_pkg::ADDR_RST;
		end else if (ce) begin
			int_addr_ff <= nxt_int_addr;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= prad_pkg::DATA_RST;
		end else if (ce) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------
	// Write mask
	// ------------------------------------------------------------
	// Reserved locations masked off; the page register stays writable
	// so a strict mask can never strand the SPI view on one page
	for (genvar i = 0; i < MAP_DEPTH; i++) begin : g_mask
		assign wr_mask[i] = WRITABLE[i] ||
			(i == int'(prad_pkg::PAGE_REG_ADDR));
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	assign acc.wr    = wr_take;
	assign acc.addr  = nxt_addr;
	assign acc.wdata = wdata;

	prad_store #(
		.DEPTH (MAP_DEPTH)
	) prad_store_inst (
		.clk      (clk),
		.resetn   (resetn),
		.ce       (ce),
		.writable (wr_mask),
		.acc      (acc.mem)
	);

	// ------------------------------------------------------------
	// Limitations
	// ------------------------------------------------------------
	// Reads of reserved locations return whatever the array holds;
	// no value is promised there, so none is forced.
	// A page change takes effect for the request after the write,
	// never for the write that carries it.
endmodule : prad_top

//--- dv/prad_assertions.sv
// Checker: address resolution of the decoder
`timescale 1ns/1ps
module prad_assertions (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       ce,
	input wire logic       is_spi,
	input wire logic       req,
	input wire logic       wr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       ack_ff,
	input wire logic [7:0] int_addr_ff,
	input wire logic       page_ff
);
	wire logic page_wr;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	assign page_wr = ce && req && wr &&
		((!is_spi && addr == prad_pkg::PAGE_REG_ADDR) ||
		 (is_spi && page_ff && addr[6:0] == prad_pkg::PAGE_REG_ADDR[6:0]));

	sequence s_take;
		ce && req;
	endsequence
	sequence s_spi;
		ce && req && is_spi;
	endsequence
	sequence s_i2c;
		ce && req && !is_spi;
	endsequence

	AST_I2C: assert property (
		s_i2c |=> int_addr_ff == $past(addr))
		else $error("I2C internal address differs from bus address");
	AST_SPI: assert property (
		s_spi |=> int_addr_ff == {~$past(page_ff), $past(addr[6:0])})
		else $error("SPI internal address not resolved from page");
	AST_SPI_PAGE0: assert property (
		ce && req && is_spi && !page_ff |=> int_addr_ff[7])
		else $error("SPI page 0 access left the upper half");
	AST_SPI_PAGE1: assert property (
		ce && req && is_spi && page_ff |=> !int_addr_ff[7])
		else $error("SPI page 1 access left the lower half");
	AST_ACK: assert property (
		s_take |=> ack_ff)
		else $error("Accepted request not answered");
	AST_ACK_IDLE: assert property (
		ce && !req |=> !ack_ff)
		else $error("Answer raised without request");
	AST_FREEZE: assert property (
		!ce |=> $stable(ack_ff) && $stable(int_addr_ff))
		else $error("State moved while clock enable low");
	AST_PAGE_WR: assert property (
		page_wr |=> page_ff == $past(wdata[prad_pkg::PAGE_BIT]))
		else $error("Page selector write not taken");
	AST_PAGE_HOLD: assert property (
		!page_wr |=> $stable(page_ff))
		else $error("Page selector moved without a write");
endmodule : prad_assertions
bind prad_top prad_assertions prad_assertions_inst (
	.clk         (clk),
	.resetn      (resetn),
	.ce          (ce),
	.is_spi      (is_spi),
	.req         (req),
	.wr          (wr),
	.addr        (addr),
	.wdata       (wdata),
	.ack_ff      (ack_ff),
	.int_addr_ff (int_addr_ff),
	.page_ff     (page_ff)
);

//--- dv/prad_host.sv
// Host model: one register access per call
`timescale 1ns/1ps
module prad_host (
	input  wire logic  clk,
	output logic       req    = 1'h0,
	output logic       wr     = 1'h0,
	output logic       is_spi = 1'h0,
	output logic [7:0] addr   = 8'h00,
	output logic [7:0] wdata  = 8'h00
);
	task automatic access(input logic s, w, input logic [7:0] a, d);
		@(negedge clk);
		{req, is_spi, wr, addr, wdata} = {1'h1, s, w, a, d};
		@(negedge clk);
		req = 1'h0;
	endtask : access
endmodule : prad_host

//--- dv/paged_register_address_decoder_bench.sv
// Bench: both address paths and page switching
`timescale 1ns/1ps
module paged_register_address_decoder_bench;
	logic            clk    = 1'h0;
	logic            resetn = 1'h0;
	logic            ce     = 1'h1;
	wire logic       req, wr, is_spi, ack_ff, page_ff;
	wire logic [7:0] addr, wdata, rdata_ff, int_addr_ff;
	int              n_fail   = 0;
	int              compares = 0;
	always #12.5 clk = ~clk;
	prad_host prad_host_inst (
		.clk    (clk),
		.req    (req),
		.wr     (wr),
		.is_spi (is_spi),
		.addr   (addr),
		.wdata  (wdata)
	);
	prad_top prad_top_inst (
		.clk         (clk),
		.resetn      (resetn),
		.ce          (ce),
		.is_spi      (is_spi),
		.req         (req),
		.wr          (wr),
		.addr        (addr),
		.wdata       (wdata),
		.ack_ff      (ack_ff),
		.rdata_ff    (rdata_ff),
		.int_addr_ff (int_addr_ff),
		.page_ff     (page_ff)
	);
	// Outputs packed as ack, internal address, read data, page
	task automatic check(input string nm, input logic [17:0] e, g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : check
	task automatic go(input logic s, w, input logic [7:0] a, d, x, r,
			input logic p);
		prad_host_inst.access(s, w, a, d);
		check("ack_addr_rdata_page", {1'h1, x, r, p},
			{ack_ff, int_addr_ff, rdata_ff, page_ff});
	endtask : go
	task automatic t_i2c;
		go(1'h0,1'h1,8'hC5,8'h5A,8'hC5,8'h00,1'h0);
		go(1'h0,1'h0,8'hC5,8'h00,8'hC5,8'h5A,1'h0);
	endtask : t_i2c
	task automatic t_page;
		go(1'h1,1'h0,8'h45,8'h00,8'hC5,8'h5A,1'h0);
		go(1'h0,1'h1,8'h73,8'h10,8'h73,8'h00,1'h1);
		go(1'h1,1'h0,8'hC5,8'h00,8'h45,8'h00,1'h1);
		go(1'h0,1'h0,8'hC5,8'h00,8'hC5,8'h5A,1'h1);
		go(1'h1,1'h1,8'h73,8'h00,8'h73,8'h10,1'h0);
		go(1'h1,1'h1,8'h05,8'hA5,8'h85,8'h00,1'h0);
		go(1'h0,1'h0,8'h85,8'h00,8'h85,8'hA5,1'h0);
	endtask : t_page
	task automatic t_freeze;
		@(negedge clk);
		ce = 1'h0;
		prad_host_inst.access(1'h0, 1'h1, 8'h73, 8'h10);
		check("frozen", {1'h0, 8'h85, 8'hA5, 1'h0},
			{ack_ff, int_addr_ff, rdata_ff, page_ff});
		ce = 1'h1;
		go(1'h0,1'h0,8'h73,8'h00,8'h73,8'h00,1'h0);
	endtask : t_freeze
	task automatic t_reset;
		go(1'h0,1'h1,8'h73,8'h10,8'h73,8'h00,1'h1);
		@(negedge clk);
		resetn = 1'h0;
		repeat (2) @(negedge clk);
		check("in_reset", 18'h00000,
			{ack_ff, int_addr_ff, rdata_ff, page_ff});
		resetn = 1'h1;
		go(1'h0,1'h0,8'h85,8'h00,8'h85,8'h00,1'h0);
		go(1'h1,1'h0,8'h05,8'h00,8'h85,8'h00,1'h0);
	endtask : t_reset
	task automatic print_verdict;
		if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20) @(negedge clk);
		resetn = 1'h1;
		t_i2c();
		t_page();
		t_freeze();
		t_reset();
		print_verdict();
	end
endmodule : paged_register_address_decoder_bench
